// ---- pkg/boot_mode_pkg.sv ----
// Package with boot-mode types, register map and constants for the boot-mode select block.
`default_nettype none
package boot_mode_pkg;

  // ----------------------------------------------------------------
  // Boot modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_NONE,
    MODE_HOST,
    MODE_LINK,
    MODE_ROM,
    MODE_RESERVED
  } boot_mode_t;

  // ----------------------------------------------------------------
  // Configuration straps of one group
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rom_boot_sel;
    logic link_boot_sel;
    logic boot_mem_select;
  } boot_straps_t;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_STATUS_ADDR = 4'h0;
  localparam logic [3:0] BUS_OWNER_ADDR   = 4'h4;
  localparam logic [3:0] STRAP_RAW_ADDR   = 4'h8;
  localparam logic [3:0] GROUP_ID_ADDR    = 4'hc;

  localparam int MODE_A_LSB    = 0;
  localparam int MODE_BCD_LSB  = 4;
  localparam int LOCKED_BIT    = 8;
  localparam int OWN_A_BIT     = 0;
  localparam int OWN_BCD_BIT   = 1;

  localparam logic [1:0] OWNER_RESET  = 2'h0;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // Arbitrary identification value.
  localparam logic [31:0] GROUP_ID_VALUE = 32'h0000_b007;

endpackage : boot_mode_pkg
`default_nettype wire

// ---- verilog/boot_mode_decode.sv ----
// Decoder from one group's configuration straps to its boot mode.
`timescale 1ns/1ps
`default_nettype none
module boot_mode_decode
  import boot_mode_pkg::*;
(
  input  wire boot_straps_t straps,
  output var  boot_mode_t   mode
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb begin
    if (straps.rom_boot_sel && !straps.link_boot_sel) begin
      mode = MODE_ROM;
    end else if (straps.rom_boot_sel) begin
      mode = MODE_RESERVED;
    end else if (straps.link_boot_sel) begin
      mode = straps.boot_mem_select ? MODE_LINK : MODE_RESERVED;
    end else begin
      mode = straps.boot_mem_select ? MODE_HOST : MODE_NONE;
    end
  end

endmodule : boot_mode_decode
`default_nettype wire

// ---- verilog/boot_mode_select.sv ----
// Boot-mode select block with AXI4-Lite status and bus-ownership registers.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module boot_mode_select
  import boot_mode_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        rom_boot_sel_grp_a,
  input  wire logic        link_boot_sel_grp_a,
  input  wire logic        boot_mem_select_grp_a,
  output logic             boot_mem_select_grp_a_drive,
  output logic             boot_mem_select_grp_a_oe_n,
  input  wire logic        rom_boot_sel_grp_bcd,
  input  wire logic        link_boot_sel_grp_bcd,
  input  wire logic        boot_mem_select_grp_bcd,
  output logic             boot_mem_select_grp_bcd_drive,
  output logic             boot_mem_select_grp_bcd_oe_n,
  input  wire logic        boot_rom_access_a,
  input  wire logic        boot_rom_access_bcd,
  output var boot_mode_t   mode_grp_a,
  output var boot_mode_t   mode_grp_bcd,
  output logic             insn_cycle_en,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  if (ADDR_W < 4) begin : g_addr_w_check
    $error("ADDR_W must be at least 4");
  end

  // ----------------------------------------------------------------
  // Strap decode
  // ----------------------------------------------------------------
  boot_straps_t straps_a;
  boot_straps_t straps_bcd;
  boot_mode_t   dec_a;
  boot_mode_t   dec_bcd;

  assign straps_a   = '{rom_boot_sel_grp_a, link_boot_sel_grp_a, boot_mem_select_grp_a};
  assign straps_bcd = '{rom_boot_sel_grp_bcd, link_boot_sel_grp_bcd, boot_mem_select_grp_bcd};

  boot_mode_decode u_dec_a (
    .straps (straps_a),
    .mode   (dec_a)
  );

  boot_mode_decode u_dec_bcd (
    .straps (straps_bcd),
    .mode   (dec_bcd)
  );

  // ----------------------------------------------------------------
  // Mode latch
  // ----------------------------------------------------------------
  boot_mode_t mode_a_q;
  boot_mode_t mode_a_d;
  boot_mode_t mode_bcd_q;
  boot_mode_t mode_bcd_d;
  logic       locked_q;
  logic       locked_d;

  always_comb begin
    mode_a_d   = mode_a_q;
    mode_bcd_d = mode_bcd_q;
    locked_d   = 1'b1;
    if (!aresetn) begin
      mode_a_d   = dec_a;
      mode_bcd_d = dec_bcd;
      locked_d   = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    mode_a_q   <= mode_a_d;
    mode_bcd_q <= mode_bcd_d;
    locked_q   <= locked_d;
  end

  assign mode_grp_a   = mode_a_q;
  assign mode_grp_bcd = mode_bcd_q;
  assign insn_cycle_en = locked_q;

  // ----------------------------------------------------------------
  // Boot memory select pins
  // ----------------------------------------------------------------
  logic [1:0] owner_q;
  logic [1:0] owner_d;
  logic       cs_n_a_q;
  logic       cs_n_a_d;
  logic       cs_n_bcd_q;
  logic       cs_n_bcd_d;
  logic       oen_a_q;
  logic       oen_a_d;
  logic       oen_bcd_q;
  logic       oen_bcd_d;

  always_comb begin
    cs_n_a_d   = !(boot_rom_access_a && owner_q[OWN_A_BIT]);
    cs_n_bcd_d = !(boot_rom_access_bcd && owner_q[OWN_BCD_BIT]);
    oen_a_d   = !(locked_q && mode_a_q == MODE_ROM && owner_q[OWN_A_BIT]);
    oen_bcd_d = !(locked_q && mode_bcd_q == MODE_ROM && owner_q[OWN_BCD_BIT]);
    if (!aresetn) begin
      cs_n_a_d   = 1'b1;
      cs_n_bcd_d = 1'b1;
      oen_a_d   = 1'b1;
      oen_bcd_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    cs_n_a_q   <= cs_n_a_d;
    cs_n_bcd_q <= cs_n_bcd_d;
    oen_a_q   <= oen_a_d;
    oen_bcd_q <= oen_bcd_d;
  end

  assign boot_mem_select_grp_a_drive   = cs_n_a_q;
  assign boot_mem_select_grp_bcd_drive = cs_n_bcd_q;
  assign boot_mem_select_grp_a_oe_n   = oen_a_q;
  assign boot_mem_select_grp_bcd_oe_n = oen_bcd_q;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic              aw_hold_q;
  logic              aw_hold_d;
  logic [ADDR_W-1:0] awaddr_q;
  logic [ADDR_W-1:0] awaddr_d;
  logic              w_hold_q;
  logic              w_hold_d;
  logic [31:0]       wdata_q;
  logic [31:0]       wdata_d;
  logic [3:0]        wstrb_q;
  logic [3:0]        wstrb_d;
  logic              bvalid_q;
  logic              bvalid_d;
  logic [1:0]        bresp_q;
  logic [1:0]        bresp_d;
  logic              rvalid_q;
  logic              rvalid_d;
  logic [31:0]       rdata_q;
  logic [31:0]       rdata_d;
  logic [1:0]        rresp_q;
  logic [1:0]        rresp_d;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [3:0] w;
    w = a[3:0];
    if (w == MODE_STATUS_ADDR) begin
      mapped = 1'b1;
    end else if (w == BUS_OWNER_ADDR) begin
      mapped = 1'b1;
    end else if (w == STRAP_RAW_ADDR) begin
      mapped = 1'b1;
    end else if (w == GROUP_ID_ADDR) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
    if ((a >> 4) != '0) begin
      mapped = 1'b0;
    end
  endfunction : mapped

  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;

  always_comb begin
    logic              have_aw;
    logic              have_w;
    logic [ADDR_W-1:0] wa;
    logic [31:0]       wd;
    logic [3:0]        ws;
    have_aw   = aw_hold_q || (s_axi_awvalid && s_axi_awready);
    have_w    = w_hold_q || (s_axi_wvalid && s_axi_wready);
    wa        = aw_hold_q ? awaddr_q : s_axi_awaddr;
    wd        = w_hold_q ? wdata_q : s_axi_wdata;
    ws        = w_hold_q ? wstrb_q : s_axi_wstrb;
    aw_hold_d = have_aw;
    awaddr_d  = wa;
    w_hold_d  = have_w;
    wdata_d   = wd;
    wstrb_d   = ws;
    bvalid_d  = bvalid_q && !s_axi_bready;
    bresp_d   = bresp_q;
    owner_d   = owner_q;
    if (have_aw && have_w) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = mapped(wa) ? RESP_OKAY : RESP_SLVERR;
      if (wa[3:0] == BUS_OWNER_ADDR && mapped(wa) && ws[0]) begin
        owner_d = wd[1:0];
      end
    end
    rvalid_d = rvalid_q && !s_axi_rready;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_d  = 32'h0;
      if (s_axi_araddr[3:0] == MODE_STATUS_ADDR) begin
        rdata_d[MODE_A_LSB+:3]   = mode_a_q;
        rdata_d[MODE_BCD_LSB+:3] = mode_bcd_q;
        rdata_d[LOCKED_BIT]      = locked_q;
      end else if (s_axi_araddr[3:0] == BUS_OWNER_ADDR) begin
        rdata_d[1:0] = owner_q;
      end else if (s_axi_araddr[3:0] == STRAP_RAW_ADDR) begin
        rdata_d[2:0] = straps_a;
        rdata_d[6:4] = straps_bcd;
      end else if (s_axi_araddr[3:0] == GROUP_ID_ADDR) begin
        rdata_d = GROUP_ID_VALUE;
      end
      if (!mapped(s_axi_araddr)) begin
        rdata_d = 32'h0;
      end
    end
    if (!aresetn) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b0;
      bresp_d   = RESP_OKAY;
      rvalid_d  = 1'b0;
      rresp_d   = RESP_OKAY;
      rdata_d   = 32'h0;
      owner_d   = OWNER_RESET;
    end
  end

  always_ff @(posedge aclk) begin
    aw_hold_q <= aw_hold_d;
    awaddr_q  <= awaddr_d;
    w_hold_q  <= w_hold_d;
    wdata_q   <= wdata_d;
    wstrb_q   <= wstrb_d;
    bvalid_q  <= bvalid_d;
    bresp_q   <= bresp_d;
    rvalid_q  <= rvalid_d;
    rdata_q   <= rdata_d;
    rresp_q   <= rresp_d;
    owner_q   <= owner_d;
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_ROM_DECODE: assert property (@(posedge aclk) disable iff (!aresetn)
    (rom_boot_sel_grp_a && !link_boot_sel_grp_a) |-> dec_a == MODE_ROM)
    else $error("EPROM straps did not decode to EPROM mode.");
  AST_NO_ROM_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    !rom_boot_sel_grp_bcd |-> dec_bcd != MODE_ROM)
    else $error("EPROM mode decoded with EPROM select low.");
  AST_LINK: assert property (@(posedge aclk) disable iff (!aresetn)
    (!rom_boot_sel_grp_a && link_boot_sel_grp_a && boot_mem_select_grp_a) |-> dec_a == MODE_LINK)
    else $error("Link straps did not decode to link mode.");
  AST_TABLE: assert property (@(posedge aclk) disable iff (!aresetn)
    (straps_bcd == 3'b001 |-> dec_bcd == MODE_HOST) and (straps_bcd == 3'b000 |-> dec_bcd == MODE_NONE)
    and (straps_bcd == 3'b010 |-> dec_bcd == MODE_RESERVED))
    else $error("Boot mode table decode mismatch.");
  AST_OE_ROM_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
    !boot_mem_select_grp_a_oe_n |-> $past(mode_a_q) == MODE_ROM)
    else $error("Memory select driven outside EPROM mode.");
  AST_OWNER: assert property (@(posedge aclk) disable iff (!aresetn)
    (!boot_mem_select_grp_bcd_oe_n && $past(aresetn)) |-> $past(owner_q[OWN_BCD_BIT]))
    else $error("Memory select driven by a non-owner.");
  AST_CS: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(aresetn) && $past(boot_rom_access_a) && $past(owner_q[OWN_A_BIT])) |-> !boot_mem_select_grp_a_drive)
    else $error("Chip select not asserted for an owned boot access.");
  AST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> $stable(mode_a_q) && $stable(mode_bcd_q))
    else $error("Boot mode changed after reset release.");
  AST_RESET_TRI: assert property (@(posedge aclk)
    $past(!aresetn) |-> boot_mem_select_grp_a_oe_n && boot_mem_select_grp_bcd_oe_n)
    else $error("Memory select driven during reset.");

endmodule : boot_mode_select
`default_nettype wire

// ---- tb/boot_partner.sv ----
// Far-side model of one boot-memory select pin: strap resistor and boot memory load.
`timescale 1ns/1ps
`default_nettype none
module boot_partner (
  input  wire logic aclk,
  input  wire logic strap_level,
  input  wire logic cs_n,
  input  wire logic oe_n,
  output logic      pin,
  output var int    selects
);
  // ----------------------------------------------------------------
  // Pin level
  // ----------------------------------------------------------------
  // The strap resistor holds the pin while the device leaves it released.
  assign pin = oe_n ? strap_level : cs_n;

  // ----------------------------------------------------------------
  // Boot memory
  // ----------------------------------------------------------------
  int count_q = 0;
  // Counts the cycles in which the boot memory sees its chip select.
  always @(posedge aclk) begin
    if (!oe_n && !cs_n) begin
      count_q <= count_q + 1;
    end
  end
  assign selects = count_q;
endmodule : boot_partner
`default_nettype wire

// ---- tb/test_boot_mode_select.sv ----
// Self-checking testbench for the boot-mode select block.
`timescale 1ns/1ps
`default_nettype none
module test_boot_mode_select
  import boot_mode_pkg::*;
;
  logic        aclk, aresetn, acc_a, acc_b, pin_a, pin_b, o_a, o_b, oe_n_a, oe_n_b, insn_en;
  logic [2:0]  sa, sb;
  boot_mode_t  mode_a, mode_b;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  logic [33:0] exp_q[$];
  int          failures, comparisons, seed, sel_a, sel_b;

  // ----------------------------------------------------------------
  // Clock, design and far side
  // ----------------------------------------------------------------
  initial aclk = 1'b0;
  always #25 aclk = ~aclk;

  boot_mode_select #(.ADDR_W(4)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .rom_boot_sel_grp_a(sa[2]), .link_boot_sel_grp_a(sa[1]), .boot_mem_select_grp_a(pin_a),
    .boot_mem_select_grp_a_drive(o_a), .boot_mem_select_grp_a_oe_n(oe_n_a),
    .rom_boot_sel_grp_bcd(sb[2]), .link_boot_sel_grp_bcd(sb[1]), .boot_mem_select_grp_bcd(pin_b),
    .boot_mem_select_grp_bcd_drive(o_b), .boot_mem_select_grp_bcd_oe_n(oe_n_b),
    .boot_rom_access_a(acc_a), .boot_rom_access_bcd(acc_b),
    .mode_grp_a(mode_a), .mode_grp_bcd(mode_b), .insn_cycle_en(insn_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  boot_partner i_far_a (.aclk(aclk), .strap_level(sa[0]), .cs_n(o_a), .oe_n(oe_n_a), .pin(pin_a), .selects(sel_a));
  boot_partner i_far_b (.aclk(aclk), .strap_level(sb[0]), .cs_n(o_b), .oe_n(oe_n_b), .pin(pin_b), .selects(sel_b));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  function automatic boot_mode_t exp_mode(input logic [2:0] s);
    if (s[2]) return s[1] ? MODE_RESERVED : MODE_ROM;
    case (s[1:0])
      2'h0:    return MODE_NONE;
      2'h1:    return MODE_HOST;
      2'h3:    return MODE_LINK;
      default: return MODE_RESERVED;
    endcase
  endfunction : exp_mode

  task automatic axi_write(input logic [3:0] addr, input logic [31:0] data, input logic [1:0] exp_resp = RESP_OKAY);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    awaddr  <= addr;
    wdata   <= data;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin aw_done = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready) begin w_done = 1'b1; wvalid <= 1'b0; end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    check("bresp", {30'h0, bresp}, {30'h0, exp_resp});
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [3:0] addr, input logic [31:0] exp, input logic [1:0] exp_resp = RESP_OKAY);
    araddr  <= addr;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    exp_q.push_back({exp_resp, exp});
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask : axi_read

  // Compares each read answer with the oldest expected word.
  always @(posedge aclk) begin
    logic [33:0] note;
    if (rvalid && rready && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      check("rdata", rdata, note[31:0]);
      check("rresp", {30'h0, rresp}, {30'h0, note[33:32]});
    end
  end

  task automatic apply_reset(input logic [2:0] a, input logic [2:0] b);
    @(posedge aclk);
    aresetn <= 1'b0;
    sa      <= a;
    sb      <= b;
    repeat (2) @(posedge aclk);
    check("oe_n_a_rst", {31'h0, oe_n_a}, 32'h1);
    check("oe_n_b_rst", {31'h0, oe_n_b}, 32'h1);
    check("insn_rst", {31'h0, insn_en}, 32'h0);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : apply_reset

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] e;
    logic [1:0]  own;
    boot_mode_t  ma, mb;
    seed = 12109;
    failures = 0;
    comparisons = 0;
    {aresetn, acc_a, acc_b, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, sa, sb} = '0;
    for (int i = 0; i < 8; i++) begin
      ma = exp_mode(3'(i));
      mb = exp_mode(~3'(i));
      apply_reset(3'(i), ~3'(i));
      repeat (2) @(posedge aclk);
      check("mode_a", {29'h0, mode_a}, {29'h0, ma});
      check("mode_bcd", {29'h0, mode_b}, {29'h0, mb});
      check("insn_en", {31'h0, insn_en}, 32'h1);
      e = '0;
      e[LOCKED_BIT] = 1'b1;
      e[MODE_A_LSB +: 3] = ma;
      e[MODE_BCD_LSB +: 3] = mb;
      axi_read(MODE_STATUS_ADDR, e);
      axi_read(STRAP_RAW_ADDR, {25'h0, ~3'(i), 1'b0, 3'(i)});
      axi_read(BUS_OWNER_ADDR, {30'h0, OWNER_RESET});
      if (i == 0) begin
        axi_read(GROUP_ID_ADDR, GROUP_ID_VALUE);
        axi_write(4'h2, 32'h3, RESP_SLVERR);
        axi_read(4'h2, 32'h0, RESP_SLVERR);
        axi_read(BUS_OWNER_ADDR, {30'h0, OWNER_RESET});
      end
      sa <= ~3'(i);
      sb <= 3'(i);
      repeat (3) @(posedge aclk);
      check("mode_a_held", {29'h0, mode_a}, {29'h0, ma});
      check("mode_bcd_held", {29'h0, mode_b}, {29'h0, mb});
      for (int k = 0; k < 2; k++) begin
        own = (k == 1) ? 2'h3 : 2'($random(seed));
        acc_a <= (k == 1) | 1'($random(seed));
        acc_b <= (k == 1) | 1'($random(seed));
        axi_write(BUS_OWNER_ADDR, {30'h0, own});
        axi_read(BUS_OWNER_ADDR, {30'h0, own});
        repeat (3) @(posedge aclk);
        check("oe_n_a", {31'h0, oe_n_a}, {31'h0, !(ma == MODE_ROM && own[OWN_A_BIT])});
        check("oe_n_bcd", {31'h0, oe_n_b}, {31'h0, !(mb == MODE_ROM && own[OWN_BCD_BIT])});
        if (oe_n_a === 1'b0) check("cs_a", {31'h0, o_a}, {31'h0, !acc_a});
        if (oe_n_b === 1'b0) check("cs_bcd", {31'h0, o_b}, {31'h0, !acc_b});
      end
    end
    check("sel_a", {31'h0, sel_a > 0}, 32'h1);
    check("sel_bcd", {31'h0, sel_b > 0}, 32'h1);
    end_of_test();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    end_of_test();
  end
endmodule : test_boot_mode_select
`default_nettype wire
